// ---- gray_pwm_map.vh ----
// register map, field positions and reset values of the serial grayscale pwm driver
`ifndef GRAY_PWM_MAP_VH
`define GRAY_PWM_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GP_CTRL_OFS        4'h0
`define GP_STATUS_OFS      4'h4
`define GP_SHIFT_CNT_OFS   4'h8

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define GP_CTRL_PAUSE_BIT  0
`define GP_CTRL_BLANK_BIT  1
`define GP_CTRL_RESET      2'h0

// ----------------------------------------------------------------
// pin synchroniser idle levels, one bit per pin
// ----------------------------------------------------------------
`define GP_PIN_IDLE        7'h6B

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define GP_STAT_LEVEL_LSB  0
`define GP_STAT_OVF_BIT    8
`define GP_STAT_INIT_BIT   9

// ----------------------------------------------------------------
// fifo word layout
// ----------------------------------------------------------------
`define GP_WORD_DATA_BIT   0
`define GP_WORD_BANK_BIT   1
`define GP_WORD_LATCH_BIT  2
`define GP_WORD_WIDTH      3
`define GP_FIFO_DEPTH      16

`endif

// ---- gray_fifo.v ----
// small flip-flop fifo with valid and ready on both sides
`default_nettype none

module gray_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             flush_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [AW:0]      level_o
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign level_o     = count_reg;

  always @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule // gray_fifo

`default_nettype wire

// ---- gray_pwm_driver.v ----
// serial grayscale pwm led driver core with wishbone control registers
//
// How it works
// [RQ1] first bit shifted lands in channel 23 msb; last bit is channel 0 lsb.
// [RQ2] controller holds bank select low to shift six-bit correction data.
// [RQ3] correction: load six-bit bank once, latch, then image frames with latch each.
// [RQ4] both banks image: shift six-bit, then eight-bit, one latch per frame.
// [RQ5] serial input sampled and banks shifted on each shift clock rising edge.
// [RQ6] both banks copied into latches on latch strobe falling edge.
// [RQ7] one device needs 144 six-bit plus 192 eight-bit shift clocks.
// [RQ8] mean duty equals eight-bit value over 256 times six-bit over 64.
// [RQ9] counters compared bit-reversed so on-time spreads into many short pulses.
// [RQ10] comparator high only when latched value strictly exceeds counter.
// [RQ11] channel on only when both comparators are high.
// [RQ12] a zero in either latched value keeps the channel off.
// [RQ13] output low whenever either counter is all ones.
// [RQ14] bank select high feeds the eight-bit bank, low the six-bit bank.
// [RQ15] output enable pin high forces every channel off.
// [RQ16] initialise pin low resets banks, latches and counters.
// [RQ17] pwm counters advance on the separate pwm clock.
// [RQ18] serial output shows the bit leaving the last stage of the bank.
// [RQ19] shifting leaves latches and outputs alone until next latch edge.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`include "gray_pwm_map.vh"
`default_nettype none

module gray_pwm_driver #(
  parameter CHANNELS = 24,
  parameter FIFO_DEPTH = `GP_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input  wire                clk_i,
  input  wire                rst_i,
  // pins from the display controller
  input  wire                serial_gray_in_i,
  input  wire                shift_clock_i,
  input  wire                bank_select_i,
  input  wire                latch_strobe_n_i,
  input  wire                pwm_clock_i,
  input  wire                init_n_i,
  input  wire                out_enable_n_i,
  output reg                 serial_gray_out_o,
  output reg  [CHANNELS-1:0] channel_on_o,
  // wishbone slave
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [3:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o
);

  localparam SIX_W   = 6 * CHANNELS;
  localparam EIGHT_W = 8 * CHANNELS;
  localparam NPIN    = 7;
  // bit positions of the pins inside the synchroniser vectors
  localparam P_SIN   = 0;
  localparam P_SHIFT = 1;
  localparam P_BANK  = 2;
  localparam P_LATCH = 3;
  localparam P_PWM   = 4;
  localparam P_INIT  = 5;
  localparam P_EN_N  = 6;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [7:0] rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rev8[k] = v[7-k];
      end
    end
  endfunction

  function [5:0] rev6;
    input [5:0] v;
    integer k;
    begin
      for (k = 0; k < 6; k = k + 1) begin
        rev6[k] = v[5-k];
      end
    end
  endfunction

  function wr_hit;
    input       wr;
    input [3:0] adr;
    input [3:0] ofs;
    input       lane;
    begin
      wr_hit = wr & (adr == ofs) & lane;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [NPIN-1:0] pin_raw = {out_enable_n_i, init_n_i, pwm_clock_i, latch_strobe_n_i,
                             bank_select_i, shift_clock_i, serial_gray_in_i};
  reg  [NPIN-1:0] meta_reg;
  reg  [NPIN-1:0] sync_reg;
  reg  [NPIN-1:0] prev_reg;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= `GP_PIN_IDLE;
      sync_reg <= `GP_PIN_IDLE;
      prev_reg <= `GP_PIN_IDLE;
    end else begin
      meta_reg <= pin_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // idle levels above: enable off, init released, latch strobe high
  wire sin_s     = sync_reg[P_SIN];
  wire bank_s    = sync_reg[P_BANK];
  wire init_n_s  = sync_reg[P_INIT];
  wire en_n_s    = sync_reg[P_EN_N];
  wire shift_edge = sync_reg[P_SHIFT] & ~prev_reg[P_SHIFT];  // [RQ5]
  wire latch_edge = ~sync_reg[P_LATCH] & prev_reg[P_LATCH];  // [RQ6]
  wire pwm_edge   = sync_reg[P_PWM] & ~prev_reg[P_PWM];      // [RQ17]
  wire clear      = rst_i | ~init_n_s;           // [RQ16]

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg  [1:0]  ctrl_reg;
  reg         ovf_reg;
  reg  [15:0] shift_cnt_reg;
  wire        pause = ctrl_reg[`GP_CTRL_PAUSE_BIT];
  wire        blank = ctrl_reg[`GP_CTRL_BLANK_BIT];

  // ----------------------------------------------------------------
  // event fifo: shift and latch events keep their pin order
  // ----------------------------------------------------------------
  wire [`GP_WORD_WIDTH-1:0] ev_in;
  wire [`GP_WORD_WIDTH-1:0] ev_out;
  wire                      ev_in_valid = shift_edge | latch_edge;
  wire                      ev_in_ready;
  wire                      ev_out_valid;
  wire                      ev_pop = ev_out_valid & ~pause;
  wire [FIFO_AW:0]          ev_level;

  // a latch edge in the same cycle as a shift is dropped and only the shift is queued; pins are too slow for that
  assign ev_in[`GP_WORD_DATA_BIT]  = sin_s;
  assign ev_in[`GP_WORD_BANK_BIT]  = bank_s;
  assign ev_in[`GP_WORD_LATCH_BIT] = latch_edge & ~shift_edge;

  gray_fifo #(
    .WIDTH (`GP_WORD_WIDTH),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (~init_n_s),
    .in_data_i   (ev_in),
    .in_valid_i  (ev_in_valid),
    .in_ready_o  (ev_in_ready),
    .out_data_o  (ev_out),
    .out_valid_o (ev_out_valid),
    .out_ready_i (~pause),
    .level_o     (ev_level)
  );

  wire do_shift = ev_pop & ~ev_out[`GP_WORD_LATCH_BIT];
  wire do_latch = ev_pop & ev_out[`GP_WORD_LATCH_BIT];
  wire ev_bit   = ev_out[`GP_WORD_DATA_BIT];
  wire ev_bank  = ev_out[`GP_WORD_BANK_BIT];

  // ----------------------------------------------------------------
  // shift banks and latches
  // ----------------------------------------------------------------
  reg [SIX_W-1:0]   six_bit_bank;
  reg [EIGHT_W-1:0] eight_bit_bank;
  reg [SIX_W-1:0]   six_latch_reg;
  reg [EIGHT_W-1:0] eight_latch_reg;

  always @(posedge clk_i) begin
    if (clear) begin
      six_bit_bank      <= {SIX_W{1'b0}};
      eight_bit_bank    <= {EIGHT_W{1'b0}};
      six_latch_reg     <= {SIX_W{1'b0}};
      eight_latch_reg   <= {EIGHT_W{1'b0}};
      serial_gray_out_o <= 1'b0;
    end else begin
      // serial out takes the new last stage, the bit a cascaded part shifts in next
      if (do_shift) begin
        if (ev_bank) begin
          eight_bit_bank    <= {eight_bit_bank[EIGHT_W-2:0], ev_bit};  // [RQ14] [RQ1]
          serial_gray_out_o <= eight_bit_bank[EIGHT_W-2];              // [RQ18]
        end else begin
          six_bit_bank      <= {six_bit_bank[SIX_W-2:0], ev_bit};      // [RQ14] [RQ1]
          serial_gray_out_o <= six_bit_bank[SIX_W-2];                  // [RQ18]
        end
      end
      if (do_latch) begin
        six_latch_reg   <= six_bit_bank;   // [RQ6] [RQ19]
        eight_latch_reg <= eight_bit_bank; // [RQ6] [RQ19]
      end
    end
  end

  // ----------------------------------------------------------------
  // pwm counters: eight-bit runs every pwm clock, six-bit on its wrap
  // ----------------------------------------------------------------
  reg [7:0] cnt8_reg;
  reg [5:0] cnt6_reg;
  // init restarts both counters, so every part of a chain runs in step

  always @(posedge clk_i) begin
    if (clear) begin
      cnt8_reg <= 8'h00;
      cnt6_reg <= 6'h00;
    end else if (pwm_edge) begin
      cnt8_reg <= cnt8_reg + 8'h01;  // [RQ17]
      if (cnt8_reg == 8'hFF) begin
        cnt6_reg <= cnt6_reg + 6'h01;
      end
    end
  end

  // bit reversal keeps each duty exact but scatters the on-cycles
  wire [7:0] cmp8_val = rev8(cnt8_reg);  // [RQ9]
  wire [5:0] cmp6_val = rev6(cnt6_reg);  // [RQ9]
  wire [CHANNELS-1:0] pwm_on;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      wire [7:0] v8 = eight_latch_reg[8*ch+7:8*ch];
      wire [5:0] v6 = six_latch_reg[6*ch+5:6*ch];
      // strict compare: zero never wins, all-ones counter never loses [RQ12] [RQ13]
      assign pwm_on[ch] = (v8 > cmp8_val) & (v6 > cmp6_val);  // [RQ10] [RQ11] [RQ8]
    end
  endgenerate

  always @(posedge clk_i) begin
    if (clear) begin
      channel_on_o <= {CHANNELS{1'b0}};
    end else if (en_n_s || blank) begin
      channel_on_o <= {CHANNELS{1'b0}};  // [RQ15]
    end else begin
      channel_on_o <= pwm_on;            // [RQ11]
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_req & wb_we_i;
  // events that find the fifo full are lost; software sees the sticky overflow
  wire ovf_set = ev_in_valid & ~ev_in_ready;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_reg <= `GP_CTRL_RESET;
      ovf_reg  <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (wr_hit(wb_wr, wb_adr_i, `GP_CTRL_OFS, wb_sel_i[0])) begin
        ctrl_reg <= wb_dat_i[1:0];
      end
      // overflow is sticky; a new overflow beats a write-one clear
      if (ovf_set) begin
        ovf_reg <= 1'b1;
      end else if (wr_hit(wb_wr, wb_adr_i, `GP_STATUS_OFS, wb_sel_i[1]) && wb_dat_i[`GP_STAT_OVF_BIT]) begin
        ovf_reg <= 1'b0;
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `GP_CTRL_OFS:      wb_dat_o <= {30'h0000_0000, ctrl_reg};
          `GP_STATUS_OFS:    wb_dat_o <= {22'h00_0000, ~init_n_s, ovf_reg, {(8-FIFO_AW-1){1'b0}}, ev_level};
          `GP_SHIFT_CNT_OFS: wb_dat_o <= {16'h0000, shift_cnt_reg};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // shifts applied since the last latch, saturating; 336 per device when full [RQ7]
  always @(posedge clk_i) begin
    if (clear || do_latch) begin
      shift_cnt_reg <= 16'h0000;
    end else if (do_shift && shift_cnt_reg != 16'hFFFF) begin
      shift_cnt_reg <= shift_cnt_reg + 16'h0001;
    end
  end

endmodule // gray_pwm_driver

`default_nettype wire

// ---- gray_pwm_monitor.sv ----
// port checker for the grayscale pwm driver
`default_nettype none
module gray_pwm_monitor #(parameter CHANNELS = 24) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                init_n_i,
  input wire logic                out_enable_n_i,
  input wire logic                pwm_clock_i,
  input wire logic                latch_strobe_n_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [3:0]          wb_adr_i,
  input wire logic                wb_ack_o,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                serial_gray_out_o,
  input wire logic [CHANNELS-1:0] channel_on_o
);
  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
  unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i == 4'hC |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  enable_off_a: assert property (out_enable_n_i [*5] |=> channel_on_o == '0)
    else $error("channel on while disabled");
  init_clear_a: assert property (!init_n_i [*5] |=> channel_on_o == '0 && !serial_gray_out_o)
    else $error("outputs not cleared by init");
  // latency from pin to output is about five clocks, so eight quiet cycles suffice
  outputs_hold_a: assert property (
    ($stable(pwm_clock_i) && $stable(latch_strobe_n_i) && $stable(out_enable_n_i) && $stable(init_n_i)) [*8]
    |=> $stable(channel_on_o)) else $error("outputs moved without cause");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> channel_on_o == '0 && !wb_ack_o && wb_dat_o == 32'h0)
    else $error("outputs not idle in reset");
  cover property (wb_ack_o && !wb_we_i);
  cover property (channel_on_o[2]);
  cover property ($rose(serial_gray_out_o));
endmodule // gray_pwm_monitor

bind gray_pwm_driver gray_pwm_monitor #(.CHANNELS(CHANNELS)) gray_pwm_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .init_n_i(init_n_i), .out_enable_n_i(out_enable_n_i), .pwm_clock_i(pwm_clock_i),
  .latch_strobe_n_i(latch_strobe_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .serial_gray_out_o(serial_gray_out_o),
  .channel_on_o(channel_on_o));
`default_nettype wire

// ---- gray_ctrl_model.sv ----
// behavioural display controller driving the serial pins
`default_nettype none
module gray_ctrl_model (
  output var logic serial_gray_in_o,
  output var logic shift_clock_o,
  output var logic bank_select_o,
  output var logic latch_strobe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_gray_in_o = 1'b0;
    shift_clock_o = 1'b0;
    bank_select_o = 1'b0;
    latch_strobe_n_o = 1'b1;
  end
  // one bit per 48 ns; data flips once held long enough, so a late sample shows
  task automatic send_bit(input logic bank, input logic bit_val);
    bank_select_o = bank;
    serial_gray_in_o = bit_val;
    #12;
    shift_clock_o = 1'b1;
    #24;
    shift_clock_o = 1'b0;
    serial_gray_in_o = ~bit_val;
    #12;
  endtask
  task automatic latch();
    #24;
    latch_strobe_n_o = 1'b0;
    #24;
    latch_strobe_n_o = 1'b1;
    #48;
  endtask
endmodule // gray_ctrl_model
`default_nettype wire

// ---- serial_grayscale_pwm_led_driver_bench.sv ----
// self-checking bench of the grayscale pwm driver
`default_nettype none
module serial_grayscale_pwm_led_driver_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, pwm_clock_i = 1'b0, init_n_i = 1'b1, out_enable_n_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pwm_run = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [1:0]  pwm_div = 2'h0;
  wire  [31:0] wb_dat_o;
  wire  [23:0] channel_on_o;
  wire         wb_ack_o, serial_gray_out_o, serial_gray_in_i, shift_clock_i, bank_select_i, latch_strobe_n_i;
  logic [5:0]  v6 [24];
  logic [5:0]  o6 [24];
  logic [7:0]  v8 [24];
  int          cycles = 0, err_total = 0, n_compared = 0, on [4], rises;
  logic        on3_q = 1'b0;
  gray_pwm_driver gray_pwm_driver_inst (.clk_i(clk_i), .rst_i(rst_i), .serial_gray_in_i(serial_gray_in_i),
    .shift_clock_i(shift_clock_i), .bank_select_i(bank_select_i), .latch_strobe_n_i(latch_strobe_n_i),
    .pwm_clock_i(pwm_clock_i), .init_n_i(init_n_i), .out_enable_n_i(out_enable_n_i),
    .serial_gray_out_o(serial_gray_out_o), .channel_on_o(channel_on_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));
  gray_ctrl_model gray_ctrl_model_inst (.serial_gray_in_o(serial_gray_in_i), .shift_clock_o(shift_clock_i),
    .bank_select_o(bank_select_i), .latch_strobe_n_o(latch_strobe_n_i));
  initial forever #2.5 clk_i = ~clk_i;
  // pwm pin: two clocks high, two low
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    pwm_div <= pwm_div + (pwm_run ? 2'h1 : 2'h0);
    pwm_clock_i <= pwm_div[1];
    if (cycles == 95000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb_io(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] dat,
                       input logic [31:0] exp);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, dat};
    // wait for the answer however long it takes; only the global ceiling ends a hang
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    if (!we) chk(wb_dat_o, exp);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic frame(input logic check_out);
    for (int bk = 0; bk < 2; bk++)
      for (int ch = 23; ch >= 0; ch--)
        for (int b = (bk ? 7 : 5); b >= 0; b--) begin
          gray_ctrl_model_inst.send_bit(bk[0], bk ? v8[ch][b] : v6[ch][b]);
          // serial out shows the new last stage: the next old bit, or the first new bit at the end
          if (check_out && bk == 0)
            chk(serial_gray_out_o, b > 0 ? o6[ch][b-1] : (ch > 0 ? o6[ch-1][5] : v6[23][5]));
          if (check_out) chk(channel_on_o[0], 1'b0);
        end
    wb_io(1'b0, 4'h8, 4'hF, 32'h0, 32'h150);
    gray_ctrl_model_inst.latch();
    wb_io(1'b0, 4'h8, 4'hF, 32'h0, 32'h0);
  endtask
  initial begin
    for (int c = 0; c < 24; c++) begin
      v6[c] = 6'(c * 5 + 7);
      v8[c] = 8'(c * 11 + 3);
    end
    {v6[0], v8[0], v6[1], v8[1], v6[2], v8[2], v6[3], v8[3]} = {6'h3F, 8'h00, 6'h00, 8'hFF, 6'h3F, 8'hFF, 6'h0F, 8'h0F};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb_io(1'b0, 4'h0, 4'hF, 32'h0, 32'h0);
    wb_io(1'b0, 4'hC, 4'hF, 32'h0, 32'h0);
    // pause drain, overfill, clear the sticky flag, drain
    wb_io(1'b1, 4'h0, 4'h1, 32'h1, 32'h0);
    repeat (17) gray_ctrl_model_inst.send_bit(1'b0, 1'b1);
    wb_io(1'b0, 4'h4, 4'hF, 32'h0, 32'h110);
    wb_io(1'b1, 4'h4, 4'h2, 32'h100, 32'h0);
    wb_io(1'b1, 4'h0, 4'h1, 32'h0, 32'h0);
    repeat (40) @(posedge clk_i);
    wb_io(1'b0, 4'h4, 4'hF, 32'h0, 32'h0);
    init_n_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    init_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    frame(1'b0);
    pwm_run <= 1'b1;
    repeat (200) @(posedge clk_i);
    on = '{default: 0};
    rises = 0;
    repeat (65536) begin
      @(posedge clk_i);
      for (int i = 0; i < 4; i++) on[i] += channel_on_o[i];
      rises += int'(channel_on_o[3] && !on3_q);
      on3_q = channel_on_o[3];
    end
    chk(on[0], 0);
    chk(on[1], 0);
    chk(on[2], 255 * 63 * 4);
    chk(on[3], 15 * 15 * 4);
    chk(rises > 100, 1);
    out_enable_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(channel_on_o, 24'h0);
    out_enable_n_i <= 1'b0;
    o6 = v6;
    v8[0] = 8'hFF;
    frame(1'b1);
    repeat (60) @(posedge clk_i);
    chk(channel_on_o[0], 1'b1);
    test_done();
  end
endmodule // serial_grayscale_pwm_led_driver_bench
`default_nettype wire
